// ### bench/aec_ev_src.sv
`timescale 1ns/1ps
module aec_ev_src (
  // Clock
  input  wire logic aclk,
  // Pins toward the counter
  output logic      low_event_pin,
  output logic      high_event_pin,
  output logic      gate_pin
);
  // Event lines idle high, so each pulse gives one fall and one rise.
  // Phases last four cycles so the two-flop synchronisers never miss one.
  initial begin
    low_event_pin  = 1'b1;
    high_event_pin = 1'b1;
    gate_pin       = 1'b1;
  end

  task automatic pulse(input bit hi, input int n);
    repeat (n) begin
      repeat (4) @(posedge aclk);
      if (hi) high_event_pin <= 1'b0;
      else low_event_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      if (hi) high_event_pin <= 1'b1;
      else low_event_pin <= 1'b1;
    end
    repeat (6) @(posedge aclk);
  endtask : pulse

  task automatic set_gate(input logic v);
    @(posedge aclk);
    gate_pin <= v;
    repeat (6) @(posedge aclk);
  endtask : set_gate
endmodule : aec_ev_src

// ### bench/aec_tb_top.sv
`timescale 1ns/1ps
module aec_tb_top;
  import aec_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, seed;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic        low_event_pin, high_event_pin, gate_pin;
  logic        evcnt_irq_req, gate_irq_req, gate_pwm_out;
  int          failures, total_checks, n, c, hi, lo;

  aec_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .low_event_pin(low_event_pin),
    .high_event_pin(high_event_pin), .gate_pin(gate_pin),
    .evcnt_irq_req(evcnt_irq_req), .gate_irq_req(gate_irq_req),
    .gate_pwm_out(gate_pwm_out));
  aec_ev_src src (.aclk(aclk), .low_event_pin(low_event_pin),
    .high_event_pin(high_event_pin), .gate_pin(gate_pin));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Both-edge sensing sees the fall and the rise of every pulse.
  function automatic logic [31:0] exp_cnt(input logic [1:0] code,
                                          input int p);
    return (code == EDGE_BOTH) ? 32'(2 * p) : 32'(p);
  endfunction : exp_cnt

  task automatic stop_test;
    $display("failures=%0d total_checks=%0d", failures, total_checks);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic tmo;
    chk(32'h0000_0000, 32'h0000_0001);
    stop_test();
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    rs = bresp;
    if (k == 40) tmo();
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    if (k == 40) tmo();
  endtask : rdr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask : rchk

  task automatic poll(input logic [7:0] a, input logic [31:0] m, e);
    int k;
    for (k = 0; k < 400; k++) begin
      rdr(a);
      if ((rd & m) === e) break;
    end
    if (k == 400) tmo();
  endtask : poll

  // Counts cycles for which the PWM output keeps level v.
  task automatic run_len(input logic v, output int cnt);
    cnt = 0;
    while (gate_pwm_out === v && cnt < 300) begin
      @(posedge aclk);
      cnt++;
    end
    if (cnt == 300) tmo();
  endtask : run_len

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    seed = 32'h1c0b_6d8a;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rchk(ADDR_CTL_STATUS, 32'h0000_0000);
    rchk(ADDR_CLK_CTL, 32'h0000_0000);
    rchk(ADDR_CLK_STOP, 32'h0000_00FF);
    rdr(8'h28);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(8'h28, 32'h0000_0000);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(ADDR_IRQ_EN, 32'h0000_0003);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    for (c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      n = int'(seed[1:0]) + 1;
      wr(ADDR_CLK_CTL, 32'(c));
      wr(ADDR_CTL_STATUS, 32'h0000_000C);
      wr(ADDR_CTL_STATUS, 32'h0000_000F);
      src.pulse(1'b0, n);
      rchk(ADDR_LOWER, exp_cnt(2'(c), n));
    end
    wr(ADDR_CTL_STATUS, 32'h0000_0003);
    src.pulse(1'b0, 2);
    rchk(ADDR_LOWER, 32'(n));
    wr(ADDR_CTL_STATUS, 32'h0000_000C);
    rchk(ADDR_LOWER, 32'h0000_0000);
    wr(ADDR_CTL_STATUS, 32'h0000_000F);
    src.set_gate(1'b0);
    rchk(ADDR_IRQ_FLAG, 32'h0000_0002);
    chk({31'h0, gate_irq_req}, 32'h0000_0001);
    src.pulse(1'b0, 3);
    rchk(ADDR_LOWER, 32'h0000_0000);
    wr(ADDR_IRQ_FLAG, 32'h0000_0000);
    src.set_gate(1'b1);
    rchk(ADDR_IRQ_FLAG, 32'h0000_0000);
    wr(ADDR_CLK_STOP, 32'h0000_00F7);
    rchk(ADDR_CLK_STOP, 32'h0000_00F7);
    src.pulse(1'b0, 3);
    rchk(ADDR_LOWER, 32'h0000_0000);
    wr(ADDR_CLK_STOP, 32'h0000_00FF);
    src.pulse(1'b0, 1);
    rchk(ADDR_LOWER, 32'h0000_0001);
    wr(ADDR_CTL_STATUS, 32'h0000_001C);
    wr(ADDR_CLK_CTL, 32'h0000_0014);
    wr(ADDR_CTL_STATUS, 32'h0000_001F);
    src.pulse(1'b1, 3);
    rchk(ADDR_UPPER, 32'h0000_0003);
    poll(ADDR_CTL_STATUS, 32'h0000_0040, 32'h0000_0040);
    chk({31'h0, evcnt_irq_req}, 32'h0000_0001);
    rchk(ADDR_UPPER, 32'h0000_0003);
    wr(ADDR_CTL_STATUS, 32'h0000_001F);
    rdr(ADDR_CTL_STATUS);
    chk(rd & 32'h0000_0040, 32'h0000_0000);
    wr(ADDR_CTL_STATUS, 32'h0000_000C);
    wr(ADDR_CLK_CTL, 32'h0000_0010);
    wr(ADDR_CTL_STATUS, 32'h0000_000F);
    poll(ADDR_UPPER, 32'h0000_00FF, 32'h0000_0001);
    rdr(ADDR_CTL_STATUS);
    chk(rd & 32'h0000_00C0, 32'h0000_0000);
    wr(ADDR_CTL_STATUS, 32'h0000_0003);
    wr(ADDR_PWM_CMP, 32'h0000_0005);
    wr(ADDR_PWM_DATA, 32'h0000_A5C3);
    wstrb <= 4'h1;
    wr(ADDR_PWM_DATA, 32'h0000_FF77);
    wstrb <= 4'hF;
    rchk(ADDR_PWM_DATA, 32'h0000_A577);
    wr(ADDR_PWM_DATA, 32'h0000_0001);
    wr(ADDR_IRQ_FLAG, 32'h0000_0000);
    wr(ADDR_EDGE_GATE, 32'h0000_0005);
    run_len(1'b0, lo);
    run_len(1'b1, hi);
    run_len(1'b0, lo);
    run_len(1'b1, hi);
    chk(32'(lo), 32'h0000_0004);
    chk(32'(hi), 32'h0000_0008);
    rchk(ADDR_IRQ_FLAG, 32'h0000_0002);
    stop_test();
  end
endmodule : aec_tb_top

// ### src/aec_pkg.sv
package aec_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CLK_CTL    = 8'h04;
  localparam logic [7:0] ADDR_EDGE_GATE  = 8'h08;
  localparam logic [7:0] ADDR_UPPER      = 8'h0C;
  localparam logic [7:0] ADDR_LOWER      = 8'h10;
  localparam logic [7:0] ADDR_IRQ_FLAG   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h18;
  localparam logic [7:0] ADDR_PWM_CMP    = 8'h1C;
  localparam logic [7:0] ADDR_PWM_DATA   = 8'h20;
  localparam logic [7:0] ADDR_CLK_STOP   = 8'h24;
  // counter_ctl_status fields.
  localparam int CS_OVH   = 7;
  localparam int CS_OVL   = 6;
  localparam int CS_SPLIT = 4;
  localparam int CS_UPPER_COUNT_ENABLE  = 3;
  localparam int CS_LOWER_COUNT_ENABLE  = 2;
  localparam int CS_UPPER_RESET_CTL  = 1;
  localparam int CS_LOWER_RESET_CTL  = 0;
  // counter_clock_ctl fields, low bit of each 2-bit field.
  localparam int CC_HCLK  = 6;
  localparam int CC_LCLK  = 4;
  localparam int CC_HEDGE = 2;
  localparam int CC_LEDGE = 0;
  // edge_gate_sel_reg fields.
  localparam int EG_GEDGE = 0;
  localparam int EG_PWMEN = 2;
  localparam int EG_PWMCK = 3;
  // Interrupt flag and enable bits.
  localparam int IF_EVCNT = 0;
  localparam int IF_GATE  = 1;
  // module_clock_stop_2 standby bit and writable mask.
  localparam int          CKS_STANDBY = 3;
  localparam logic [7:0] CKS_RW_MASK = 8'h1B;
  // Reset values.
  localparam logic [7:0] RST_CTL_STATUS = 8'h00;
  localparam logic [7:0] RST_CLK_CTL    = 8'h00;
  localparam logic [7:0] RST_EDGE_GATE  = 8'h00;
  localparam logic [7:0] RST_CLK_STOP   = 8'hFF;
  // Clock source and edge encodings.
  localparam logic [1:0] SRC_PIN   = 2'h0;
  localparam logic [1:0] SRC_DIV2  = 2'h1;
  localparam logic [1:0] SRC_DIV4  = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [7:0] CNT_MAX   = 8'hFF;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : aec_pkg

// ### src/aec_top.sv
// Contract
// R1: Standby bit 0 stops counting; 1, the reset value, runs normally.
// R2: Split bit 0 chains both 8-bit counters into one 16-bit counter.
// R3: In 16-bit mode low clock select picks clock/2, /4, /8 or low pin.
// R4: Low edge select chooses which low pin transitions count.
// R5: Reset gives 16-bit mode, pin source, falling edge counting.
// R6: 16-bit wrap from FFFF clears both halves, sets upper overflow, continues.
// R7: Any overflow sets the counter interrupt flag; enable passes request.
// R8: Split bit 1 runs counters alone; upper select picks divider or high pin.
// R9: High edge select chooses which high pin transitions count.
// R10: 8-bit wrap from FF clears that counter and sets its own flag.
// R11: Without PWM gating both counters count only while gate pin is high.
// R12: Gate edges raise an interrupt on the gate vector.
// R13: Gate event sets gate flag; request only if gate enable is 1.
// R14: Gate edge select picks rising, falling or both gate edges.
// R15: With PWM gating both counters count only while PWM output is high.
// R16: PWM output edges set the same gate flag by the same select.
// R17: Software keeps PWM data below compare before enabling PWM.
// R18: PWM low for data+1 periods, repeats every compare+1, source /2../64.
// R19: Gating cuts the clock, so counts may be off by one.
// R20: In 16-bit mode the upper counter counts lower overflows.
// R21: Count enable 0 holds a counter; 1 lets clocks increment it.
// R22: Counter reset bit 0 holds the counter at zero; 1 releases it.
// R23: Overflow flag clears only by writing 0 after reading it as 1.
// R24: Pins are synchronised before they touch counters or flags.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module aec_top
  import aec_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Event and gate pins
  input  wire logic        low_event_pin,
  input  wire logic        high_event_pin,
  input  wire logic        gate_pin,
  // Interrupt requests and gate output
  output logic             evcnt_irq_req,
  output logic             gate_irq_req,
  output logic             gate_pwm_out
);

  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  clk;
    logic [7:0]  egs;
    logic [7:0]  cstop;
    logic [7:0]  up;
    logic [7:0]  lo;
    logic [1:0]  iflag;
    logic [1:0]  ien;
    logic [15:0] cmp;
    logic [15:0] dat;
    logic [15:0] pcnt;
    logic        pout;
    logic [5:0]  div;
    logic [2:0]  sl;
    logic [2:0]  sh;
    logic [2:0]  sg;
    logic        gprev;
    logic [1:0]  arm;
    logic        aw_full;
    logic [7:0]  aw_a;
    logic        w_full;
    logic [15:0] wd;
    logic [1:0]  ws;
    logic        aw_rdy;
    logic        w_rdy;
    logic        bv;
    logic [1:0]  br;
    logic        ar_rdy;
    logic        rv;
    logic [1:0]  rr;
    logic [15:0] rd;
    logic        irq_e;
    logic        irq_g;
  } aec_state_t;

  localparam aec_state_t ST_RST = '{
    ctl: RST_CTL_STATUS, clk: RST_CLK_CTL, egs: RST_EDGE_GATE,
    cstop: RST_CLK_STOP, aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1,
    default: '0};

  aec_state_t s_reg;
  aec_state_t s_next;

  function automatic logic reg_ok(input logic [7:0] a);
    case (a)
      ADDR_CTL_STATUS, ADDR_CLK_CTL, ADDR_EDGE_GATE, ADDR_UPPER,
      ADDR_LOWER, ADDR_IRQ_FLAG, ADDR_IRQ_EN, ADDR_PWM_CMP,
      ADDR_PWM_DATA, ADDR_CLK_STOP: reg_ok = 1'b1;
      default: reg_ok = 1'b0;
    endcase
  endfunction : reg_ok

  // Encoding 3 senses falling edges, like 0.
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic rise, input logic fall);
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_BOTH: edge_hit = rise | fall;
      default:   edge_hit = fall;
    endcase
  endfunction : edge_hit

  function automatic logic src_tick(input logic [1:0] sel,
                                    input logic pin_ev,
                                    input logic [5:0] dv);
    case (sel)
      SRC_PIN:  src_tick = pin_ev;
      SRC_DIV2: src_tick = dv[0];
      SRC_DIV4: src_tick = &dv[1:0];
      default:  src_tick = &dv[2:0];
    endcase
  endfunction : src_tick

  logic       run;
  logic       split;
  logic       pwm_en;
  logic       gate;
  logic       ptick;
  logic       lo_clk;
  logic       lo_wrap;
  logic       hi_src;
  logic       hi_clk;
  logic       ovh_set;
  logic       ovl_set;
  logic       gev;
  logic       commit;
  logic [2:0] pck;

  assign run    = s_reg.cstop[CKS_STANDBY]; // R1
  assign split  = s_reg.ctl[CS_SPLIT];
  assign pwm_en = s_reg.egs[EG_PWMEN];
  assign pck    = s_reg.egs[EG_PWMCK +: 3];
  // Codes above 5 saturate at the slowest source.
  assign ptick  = &(s_reg.div | (6'h3E << ((pck > 3'h5) ? 3'h5 : pck))); // R18
  // Gated from the synchronised gate pin level or the PWM output, so a count may slip by one. R19
  assign gate   = pwm_en ? s_reg.pout : s_reg.sg[1]; // R11 R15
  assign lo_clk = run & gate & s_reg.ctl[CS_LOWER_COUNT_ENABLE] & s_reg.ctl[CS_LOWER_RESET_CTL]
    & src_tick(s_reg.clk[CC_LCLK +: 2], // R3
               edge_hit(s_reg.clk[CC_LEDGE +: 2], // R4
                        s_reg.sl[1] & ~s_reg.sl[2],
                        ~s_reg.sl[1] & s_reg.sl[2]), s_reg.div); // R21
  assign lo_wrap = lo_clk & (s_reg.lo == CNT_MAX);
  assign hi_src  = split
    ? src_tick(s_reg.clk[CC_HCLK +: 2], // R8
               edge_hit(s_reg.clk[CC_HEDGE +: 2], // R9
                        s_reg.sh[1] & ~s_reg.sh[2],
                        ~s_reg.sh[1] & s_reg.sh[2]), s_reg.div)
    : lo_wrap; // R2 R20
  assign hi_clk  = run & gate & s_reg.ctl[CS_UPPER_COUNT_ENABLE] & s_reg.ctl[CS_UPPER_RESET_CTL]
    & hi_src; // R21
  assign ovh_set = hi_clk & (s_reg.up == CNT_MAX); // R6 R10
  assign ovl_set = split & lo_wrap; // R10
  assign gev     = run & edge_hit(s_reg.egs[EG_GEDGE +: 2],
                                  gate & ~s_reg.gprev,
                                  ~gate & s_reg.gprev); // R12 R14 R16
  assign commit  = s_reg.aw_full & s_reg.w_full & ~s_reg.bv;

  always_comb begin
    s_next     = s_reg;
    s_next.div = s_reg.div + 6'h01;
    // Stage 0 is read only by stage 1; edges compare stages 1 and 2.
    s_next.sl  = {s_reg.sl[1:0], low_event_pin}; // R24
    s_next.sh  = {s_reg.sh[1:0], high_event_pin}; // R24
    s_next.sg  = {s_reg.sg[1:0], gate_pin}; // R24
    s_next.gprev = gate;

    // PWM phase counter; compare above data is left to software. R17
    if (!pwm_en) begin
      s_next.pcnt = '0;
      s_next.pout = 1'b0;
    end else if (run && ptick) begin
      s_next.pcnt = (s_reg.pcnt == s_reg.cmp) ? 16'h0000
                                               : s_reg.pcnt + 16'h0001;
      s_next.pout = s_next.pcnt > s_reg.dat; // R18
    end

    if (!s_reg.ctl[CS_LOWER_RESET_CTL]) begin
      s_next.lo = '0; // R22
    end else if (lo_clk) begin
      s_next.lo = s_reg.lo + 8'h01; // R6 R10
    end
    if (!s_reg.ctl[CS_UPPER_RESET_CTL]) begin
      s_next.up = '0; // R22
    end else if (hi_clk) begin
      s_next.up = s_reg.up + 8'h01;
    end

    // Bus channel capture.
    if (awvalid && s_reg.aw_rdy) begin
      s_next.aw_full = 1'b1;
      s_next.aw_a    = awaddr;
    end
    if (wvalid && s_reg.w_rdy) begin
      s_next.w_full = 1'b1;
      s_next.wd     = wdata[15:0];
      s_next.ws     = wstrb[1:0];
    end
    if (s_reg.bv && bready) begin
      s_next.bv = 1'b0;
    end
    if (commit) begin
      s_next.aw_full = 1'b0;
      s_next.w_full  = 1'b0;
      s_next.bv      = 1'b1;
      s_next.br      = reg_ok(s_reg.aw_a) ? RESP_OKAY : RESP_SLVERR;
      if (s_reg.ws[0]) begin
        case (s_reg.aw_a)
          ADDR_CTL_STATUS: begin
            s_next.ctl[5:0] = s_reg.wd[5:0];
            // Flags clear only if seen set by an earlier read. R23
            if (!s_reg.wd[CS_OVH] && s_reg.arm[1]) begin
              s_next.ctl[CS_OVH] = 1'b0;
              s_next.arm[1]      = 1'b0;
            end
            if (!s_reg.wd[CS_OVL] && s_reg.arm[0]) begin
              s_next.ctl[CS_OVL] = 1'b0;
              s_next.arm[0]      = 1'b0;
            end
          end
          ADDR_CLK_CTL:  s_next.clk = s_reg.wd[7:0];
          ADDR_EDGE_GATE: s_next.egs = s_reg.wd[7:0];
          ADDR_IRQ_FLAG: s_next.iflag = s_reg.iflag & s_reg.wd[1:0];
          ADDR_IRQ_EN:   s_next.ien = s_reg.wd[1:0];
          ADDR_PWM_CMP:  s_next.cmp[7:0] = s_reg.wd[7:0];
          ADDR_PWM_DATA: s_next.dat[7:0] = s_reg.wd[7:0];
          ADDR_CLK_STOP: s_next.cstop = (s_reg.cstop & ~CKS_RW_MASK)
                                      | (s_reg.wd[7:0] & CKS_RW_MASK);
          default: ;
        endcase
      end
      if (s_reg.ws[1] && s_reg.aw_a == ADDR_PWM_CMP) begin
        s_next.cmp[15:8] = s_reg.wd[15:8];
      end
      if (s_reg.ws[1] && s_reg.aw_a == ADDR_PWM_DATA) begin
        s_next.dat[15:8] = s_reg.wd[15:8];
      end
    end
    s_next.aw_rdy = ~s_next.aw_full;
    s_next.w_rdy  = ~s_next.w_full;

    // Read channel; reading the status arms any set flag for clearing.
    if (s_reg.rv && rready) begin
      s_next.rv     = 1'b0;
      s_next.ar_rdy = 1'b1;
    end
    if (arvalid && s_reg.ar_rdy) begin
      s_next.rv     = 1'b1;
      s_next.ar_rdy = 1'b0;
      s_next.rr     = reg_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        ADDR_CTL_STATUS: begin
          s_next.rd  = {8'h00, s_reg.ctl};
          s_next.arm = s_next.arm | s_reg.ctl[CS_OVH:CS_OVL]; // R23
        end
        ADDR_CLK_CTL:   s_next.rd = {8'h00, s_reg.clk};
        ADDR_EDGE_GATE: s_next.rd = {8'h00, s_reg.egs};
        ADDR_UPPER:     s_next.rd = {8'h00, s_reg.up};
        ADDR_LOWER:     s_next.rd = {8'h00, s_reg.lo};
        ADDR_IRQ_FLAG:  s_next.rd = {14'h0000, s_reg.iflag};
        ADDR_IRQ_EN:    s_next.rd = {14'h0000, s_reg.ien};
        ADDR_PWM_CMP:   s_next.rd = s_reg.cmp;
        ADDR_PWM_DATA:  s_next.rd = s_reg.dat;
        ADDR_CLK_STOP:  s_next.rd = {8'h00, s_reg.cstop};
        default:        s_next.rd = 16'h0000;
      endcase
    end

    // Hardware sets are applied last so they win over a clear.
    s_next.ctl[CS_OVH] = s_next.ctl[CS_OVH] | ovh_set; // R6
    s_next.ctl[CS_OVL] = s_next.ctl[CS_OVL] | ovl_set; // R10
    s_next.iflag[IF_EVCNT] = s_next.iflag[IF_EVCNT] | ovh_set
                           | ovl_set; // R7
    s_next.iflag[IF_GATE]  = s_next.iflag[IF_GATE] | gev; // R13
    s_next.irq_e = s_next.iflag[IF_EVCNT] & s_next.ien[IF_EVCNT]; // R7
    s_next.irq_g = s_next.iflag[IF_GATE] & s_next.ien[IF_GATE]; // R13
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= ST_RST; // R5
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready       = s_reg.aw_rdy;
  assign wready        = s_reg.w_rdy;
  assign bvalid        = s_reg.bv;
  assign bresp         = s_reg.br;
  assign arready       = s_reg.ar_rdy;
  assign rvalid        = s_reg.rv;
  assign rresp         = s_reg.rr;
  assign rdata         = {16'h0000, s_reg.rd};
  assign evcnt_irq_req = s_reg.irq_e;
  assign gate_irq_req  = s_reg.irq_g;
  assign gate_pwm_out  = s_reg.pout;

  AST_WRAP16: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    !split && hi_clk && s_reg.up == CNT_MAX && s_reg.lo == CNT_MAX
    |=> s_reg.ctl[CS_OVH] && s_reg.up == 8'h00 && s_reg.lo == 8'h00)
    else $error("16-bit wrap did not clear and flag");
  AST_WRAP8L: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    split && lo_wrap |=> s_reg.ctl[CS_OVL] && s_reg.lo == 8'h00
    && s_reg.iflag[IF_EVCNT])
    else $error("8-bit lower wrap mishandled");
  AST_NO_OVL16: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    !split && !s_reg.ctl[CS_OVL] |=> !s_reg.ctl[CS_OVL])
    else $error("lower flag set in 16-bit mode");
  AST_GATE_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    !gate && s_reg.ctl[CS_LOWER_RESET_CTL] |=> $stable(s_reg.lo))
    else $error("lower counter moved with gate low");
  AST_STANDBY: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    !run && s_reg.ctl[CS_UPPER_RESET_CTL] && s_reg.ctl[CS_LOWER_RESET_CTL]
    |=> $stable({s_reg.up, s_reg.lo}) && !$rose(s_reg.iflag[IF_GATE]))
    else $error("counter active in standby");
  AST_CLR_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // R22
    !s_reg.ctl[CS_UPPER_RESET_CTL] |=> s_reg.up == 8'h00)
    else $error("upper counter not held at zero");
  AST_PWM_WRAP: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    pwm_en && run && ptick && s_reg.pcnt == s_reg.cmp
    |=> s_reg.pcnt == 16'h0000 && !s_reg.pout)
    else $error("gate PWM period wrong");
  AST_GATE_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    gev |=> s_reg.iflag[IF_GATE] && (gate_irq_req == s_reg.ien[IF_GATE]))
    else $error("gate event lost");
  AST_NO_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // R23
    s_reg.ctl[CS_OVH] && !s_reg.arm[1] |=> s_reg.ctl[CS_OVH])
    else $error("upper flag cleared without read");
  AST_WRAP8H: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    split && ovh_set |=> s_reg.ctl[CS_OVH] && s_reg.up == 8'h00)
    else $error("8-bit upper wrap mishandled");
  AST_CNT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // R21
    !s_reg.ctl[CS_LOWER_COUNT_ENABLE] && s_reg.ctl[CS_LOWER_RESET_CTL] |=> $stable(s_reg.lo))
    else $error("lower counter moved with count enable low");
  AST_PWM_CUT: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    pwm_en && !s_reg.pout && s_reg.ctl[CS_UPPER_RESET_CTL] |=> $stable(s_reg.up))
    else $error("upper counter moved with PWM gate low");
  AST_EV_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    ovh_set || ovl_set |=> s_reg.iflag[IF_EVCNT]
    && (evcnt_irq_req == s_reg.ien[IF_EVCNT]))
    else $error("overflow did not raise the counter request");
  AST_CHAIN16: assert property (@(posedge aclk) disable iff (!aresetn) // R20
    !split && s_reg.ctl[CS_UPPER_RESET_CTL] && !lo_wrap |=> $stable(s_reg.up))
    else $error("upper counter moved without a lower wrap");
  AST_PWM_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    pwm_en && run && ptick && s_reg.pcnt < s_reg.dat |=> !s_reg.pout)
    else $error("gate PWM high inside its low phase");
endmodule : aec_top
